// file: iefc_pkg.sv
// constants and register map of the interrupt enable and flag block
// Functional notes
// - global enable passes or blocks the core request; irq output is not gated
// - peripheral enable gates all peripheral sources
// - flags set regardless of any enable, except the pin-change flag, which needs its per-pin mask bit set
// - timer0 enable gates timer0 overflow interrupt
// - timer0 flag set on rollover, software clears
// - external enable gates external pin interrupt
// - external flag sticky until software clears
// - pin-change enable and per-pin mask gate
// - pin-change flag shows any enabled pin change
// - first enable register gates five peripheral sources
// - second enable register gates four fault sources
// - unimplemented enable bits read zero
// - taken interrupt clears global enable, vector 0004h
// - edge select picks rising or falling external edge
// - peripheral flags latched at enable bit positions
package iefc_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W  = 8;

    localparam logic [ADDR_W-1:0] OFF_CONTROL  = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PIE_ONE  = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_PIE_TWO  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_PIR_ONE  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_PIR_TWO  = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_OPTION   = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_PC_MASK  = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_EV_STAT  = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_EV_MASK  = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_CORE     = 8'h24;

    // interrupt_control fields
    localparam int unsigned GLB_EN_BIT = 7;
    localparam int unsigned PER_EN_BIT = 6;
    localparam int unsigned T0_EN_BIT  = 5;
    localparam int unsigned EXT_EN_BIT = 4;
    localparam int unsigned PC_EN_BIT  = 3;
    localparam int unsigned T0_FL_BIT  = 2;
    localparam int unsigned EXT_FL_BIT = 1;
    localparam int unsigned PC_FL_BIT  = 0;

    // first peripheral register positions
    localparam int unsigned ADC_BIT  = 6;
    localparam int unsigned BCL_BIT  = 5;
    localparam int unsigned SSP_BIT  = 4;
    localparam int unsigned TMR2_BIT = 1;
    localparam int unsigned TMR1_BIT = 0;
    // second peripheral register positions
    localparam int unsigned UV_BIT   = 7;
    localparam int unsigned OC_BIT   = 5;
    localparam int unsigned OV_BIT   = 4;
    localparam int unsigned VIN_BIT  = 1;

    localparam logic [REG_W-1:0] PERIPH_ONE_IMPL = REG_W'((1 << ADC_BIT)
        | (1 << BCL_BIT) | (1 << SSP_BIT) | (1 << TMR2_BIT)
        | (1 << TMR1_BIT));
    localparam logic [REG_W-1:0] PERIPH_TWO_IMPL = REG_W'((1 << UV_BIT)
        | (1 << OC_BIT) | (1 << OV_BIT) | (1 << VIN_BIT));

    // option register: only the edge select lives here
    localparam int unsigned EDGE_SEL_BIT = 6;

    // block event status layout
    localparam int unsigned EV_W      = 5;
    localparam int unsigned EV_TIMER0 = 0;
    localparam int unsigned EV_EXT    = 1;
    localparam int unsigned EV_PCHG   = 2;
    localparam int unsigned EV_PERIPH = 3;
    localparam int unsigned EV_TAKEN  = 4;

    localparam logic [REG_W-1:0] CONTROL_RST = 8'h00;
    localparam logic [REG_W-1:0] PIE_RST     = 8'h00;
    localparam logic [REG_W-1:0] PIR_RST     = 8'h00;
    localparam logic [REG_W-1:0] OPTION_RST  = 8'h00;
    localparam logic [REG_W-1:0] PC_MASK_RST = 8'h00;
    localparam logic [15:0]      IRQ_VECTOR  = 16'h0004;
    localparam logic [15:0]      VECTOR_RST  = 16'h0000;
endpackage : iefc_pkg

// file: iefc_flag_if.sv
// carrier between the main block and its latched flag bank
`timescale 1ns/100ps
interface iefc_flag_if #(
    parameter int unsigned W = 8
);
    logic [W-1:0] set;
    logic         wr_en;
    logic [W-1:0] wr_data;
    logic [W-1:0] flags;
    modport bank (input set, input wr_en, input wr_data, output flags);
    modport user (output set, output wr_en, output wr_data, input flags);
endinterface : iefc_flag_if

// file: iefc_flag_bank.sv
// latched peripheral flag bank, software writable, hardware set wins
`timescale 1ns/100ps
module iefc_flag_bank
    import iefc_pkg::*;
#(
    parameter int unsigned   W    = 8,
    parameter logic [W-1:0]  IMPL = '1
) (
    input  wire logic     core_clk,
    input  wire logic     reset_n,
    iefc_flag_if.bank     fb
);
    logic [W-1:0] flags;
    logic [W-1:0] next_flags;

    always_comb begin
        next_flags = fb.wr_en ? fb.wr_data : flags;
        next_flags = (next_flags | fb.set) & IMPL;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

    assign fb.flags = flags;

    property p_set_latches;
        @(posedge core_clk) disable iff (!reset_n)
        |(fb.set & IMPL) |=> ((flags & $past(fb.set & IMPL))
                              == $past(fb.set & IMPL));
    endproperty
    flag_set_latch_a: assert property (p_set_latches)
        else $error("peripheral event did not latch its flag");
endmodule // iefc_flag_bank

// file: iefc_irq_ctrl.sv
// interrupt enable and flag control with avalon register slave
//
// Implementation choices: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
module iefc_irq_ctrl
    import iefc_pkg::*;
#(
    parameter int unsigned PC_W = 8
) (
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [DATA_W-1:0] avs_writedata,
    output logic      [DATA_W-1:0] avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              timer0_rollover,
    input  wire logic              ext_pin,
    input  wire logic [PC_W-1:0]   pin_change_in,
    input  wire logic [REG_W-1:0]  pir_one_event,
    input  wire logic [REG_W-1:0]  pir_two_event,
    input  wire logic              core_irq_taken,
    input  wire logic              core_irq_return,
    output logic                   core_irq_request,
    output logic      [15:0]       core_irq_vector,
    output logic                   irq
);
    logic [REG_W-1:0]  control;
    logic [REG_W-1:0]  next_control;
    logic [REG_W-1:0]  pie_one;
    logic [REG_W-1:0]  next_pie_one;
    logic [REG_W-1:0]  pie_two;
    logic [REG_W-1:0]  next_pie_two;
    logic [REG_W-1:0]  option;
    logic [REG_W-1:0]  next_option;
    logic [PC_W-1:0]   pin_change_mask;
    logic [PC_W-1:0]   next_pin_change_mask;
    logic [PC_W-1:0]   pin_prev;
    logic              pin_prev_valid;
    logic              ext_prev;
    logic [EV_W-1:0]   ev_status;
    logic [EV_W-1:0]   next_ev_status;
    logic [EV_W-1:0]   ev_mask;
    logic [EV_W-1:0]   next_ev_mask;
    logic              next_request;
    logic [15:0]       next_vector;
    logic [DATA_W-1:0] next_readdata;
    logic              next_waitrequest;
    logic              bus_req;
    logic              accept;
    logic              ext_edge;
    logic              pin_changed;
    logic              periph_hit;
    logic              core_hit;
    logic [EV_W-1:0]   ev_set;

    iefc_flag_if #(.W(REG_W)) pir_one_if ();
    iefc_flag_if #(.W(REG_W)) pir_two_if ();

    iefc_flag_bank #(.W(REG_W), .IMPL(PERIPH_ONE_IMPL)) u_pir_one (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .fb       (pir_one_if.bank)
    );
    iefc_flag_bank #(.W(REG_W), .IMPL(PERIPH_TWO_IMPL)) u_pir_two (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .fb       (pir_two_if.bank)
    );

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] off);
        return a[ADDR_W-1:2] == off[ADDR_W-1:2];
    endfunction

    // a write lands only on the edge where waitrequest is seen low
    assign bus_req = avs_read | avs_write;
    assign accept  = avs_write & ~avs_waitrequest;

    assign pir_one_if.set     = pir_one_event;
    assign pir_one_if.wr_en   = accept & hit(avs_address, OFF_PIR_ONE);
    assign pir_one_if.wr_data = avs_writedata[REG_W-1:0];
    assign pir_two_if.set     = pir_two_event;
    assign pir_two_if.wr_en   = accept & hit(avs_address, OFF_PIR_TWO);
    assign pir_two_if.wr_data = avs_writedata[REG_W-1:0];

    always_comb begin
        ext_edge = option[EDGE_SEL_BIT] ? (ext_pin & ~ext_prev)
                                        : (~ext_pin & ext_prev);
        pin_changed = pin_prev_valid
                    & (|((pin_change_in ^ pin_prev) & pin_change_mask));
        periph_hit = |(pir_one_if.flags & pie_one)
                   | (|(pir_two_if.flags & pie_two));
        core_hit = (control[T0_EN_BIT] & control[T0_FL_BIT])
                 | (control[EXT_EN_BIT] & control[EXT_FL_BIT])
                 | (control[PC_EN_BIT] & control[PC_FL_BIT])
                 | (control[PER_EN_BIT] & periph_hit);
        next_request = control[GLB_EN_BIT] & core_hit;
    end

    always_comb begin
        next_control         = control;
        next_pie_one         = pie_one;
        next_pie_two         = pie_two;
        next_option          = option;
        next_pin_change_mask = pin_change_mask;
        next_ev_mask         = ev_mask;
        next_vector          = core_irq_vector;
        if (accept && hit(avs_address, OFF_CONTROL)) begin
            next_control = avs_writedata[REG_W-1:0];
        end
        if (accept && hit(avs_address, OFF_PIE_ONE)) begin
            next_pie_one = avs_writedata[REG_W-1:0] & PERIPH_ONE_IMPL;
        end
        if (accept && hit(avs_address, OFF_PIE_TWO)) begin
            next_pie_two = avs_writedata[REG_W-1:0] & PERIPH_TWO_IMPL;
        end
        if (accept && hit(avs_address, OFF_OPTION)) begin
            next_option = avs_writedata[REG_W-1:0]
                        & REG_W'(1 << EDGE_SEL_BIT);
        end
        if (accept && hit(avs_address, OFF_PC_MASK)) begin
            next_pin_change_mask = avs_writedata[PC_W-1:0];
        end
        if (accept && hit(avs_address, OFF_EV_MASK)) begin
            next_ev_mask = avs_writedata[EV_W-1:0];
        end
        if (timer0_rollover) begin
            next_control[T0_FL_BIT] = 1'b1;
        end
        if (ext_edge) begin
            next_control[EXT_FL_BIT] = 1'b1;
        end
        if (pin_changed) begin
            next_control[PC_FL_BIT] = 1'b1;
        end
        // return from service re-arms the global gate
        if (core_irq_return) begin
            next_control[GLB_EN_BIT] = 1'b1;
        end
        // taken clears global enable, loads vector
        if (core_irq_taken) begin
            next_control[GLB_EN_BIT] = 1'b0;
            next_vector              = IRQ_VECTOR;
        end
    end

    always_comb begin
        ev_set            = '0;
        ev_set[EV_TIMER0] = timer0_rollover;
        ev_set[EV_EXT]    = ext_edge;
        ev_set[EV_PCHG]   = pin_changed;
        ev_set[EV_PERIPH] = |pir_one_event | (|pir_two_event);
        ev_set[EV_TAKEN]  = core_irq_taken;
        next_ev_status    = ev_status;
        if (accept && hit(avs_address, OFF_EV_STAT)) begin
            next_ev_status = ev_status & ~avs_writedata[EV_W-1:0];
        end
        // new events win over a same-cycle write-one clear
        next_ev_status = next_ev_status | ev_set;
    end

    always_comb begin
        next_readdata    = '0;
        next_waitrequest = 1'b1;
        // one wait state: answer the cycle after a request appears
        if (bus_req && avs_waitrequest) begin
            next_waitrequest = 1'b0;
            unique case (1'b1)
                hit(avs_address, OFF_CONTROL):
                    next_readdata[REG_W-1:0] = control;
                hit(avs_address, OFF_PIE_ONE):
                    next_readdata[REG_W-1:0] = pie_one;
                hit(avs_address, OFF_PIE_TWO):
                    next_readdata[REG_W-1:0] = pie_two;
                hit(avs_address, OFF_PIR_ONE):
                    next_readdata[REG_W-1:0] = pir_one_if.flags;
                hit(avs_address, OFF_PIR_TWO):
                    next_readdata[REG_W-1:0] = pir_two_if.flags;
                hit(avs_address, OFF_OPTION):
                    next_readdata[REG_W-1:0] = option;
                hit(avs_address, OFF_PC_MASK):
                    next_readdata[PC_W-1:0] = pin_change_mask;
                hit(avs_address, OFF_EV_STAT):
                    next_readdata[EV_W-1:0] = ev_status;
                hit(avs_address, OFF_EV_MASK):
                    next_readdata[EV_W-1:0] = ev_mask;
                hit(avs_address, OFF_CORE):
                    next_readdata[16:0] = {core_irq_request,
                                           core_irq_vector};
                default:
                    next_readdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            control          <= CONTROL_RST;
            pie_one          <= PIE_RST;
            pie_two          <= PIE_RST;
            option           <= OPTION_RST;
            pin_change_mask  <= PC_W'(PC_MASK_RST);
            pin_prev         <= '0;
            pin_prev_valid   <= 1'b0;
            ext_prev         <= 1'b0;
            ev_status        <= '0;
            ev_mask          <= '0;
            core_irq_request <= 1'b0;
            core_irq_vector  <= VECTOR_RST;
            avs_readdata     <= '0;
            avs_waitrequest  <= 1'b1;
            irq              <= 1'b0;
        end else begin
            control          <= next_control;
            pie_one          <= next_pie_one;
            pie_two          <= next_pie_two;
            option           <= next_option;
            pin_change_mask  <= next_pin_change_mask;
            pin_prev         <= pin_change_in;
            pin_prev_valid   <= 1'b1;
            ext_prev         <= ext_pin;
            ev_status        <= next_ev_status;
            ev_mask          <= next_ev_mask;
            core_irq_request <= next_request;
            core_irq_vector  <= next_vector;
            avs_readdata     <= next_readdata;
            avs_waitrequest  <= next_waitrequest;
            irq              <= |(next_ev_status & next_ev_mask);
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    gie_blocks_all_a: assert property (
        !control[GLB_EN_BIT] |=> !core_irq_request)
        else $error("request raised with global enable clear");
    timer0_pass_a: assert property (
        control[GLB_EN_BIT] && control[T0_EN_BIT] && control[T0_FL_BIT]
        |=> core_irq_request)
        else $error("enabled timer0 flag gave no request");
    periph_gate_a: assert property (
        !control[PER_EN_BIT]
        && !(control[T0_EN_BIT] && control[T0_FL_BIT])
        && !(control[EXT_EN_BIT] && control[EXT_FL_BIT])
        && !(control[PC_EN_BIT] && control[PC_FL_BIT])
        |=> !core_irq_request)
        else $error("peripheral source passed with gate clear");
    periph_pass_a: assert property (
        control[GLB_EN_BIT] && control[PER_EN_BIT] && periph_hit
        |=> core_irq_request)
        else $error("enabled peripheral flag gave no request");
    timer0_flag_a: assert property (
        timer0_rollover ##1 !(accept && hit(avs_address, OFF_CONTROL))
        [*3] |-> control[T0_FL_BIT])
        else $error("timer0 flag not held after rollover");
    ext_edge_a: assert property (
        option[EDGE_SEL_BIT] && $rose(ext_pin) |=> control[EXT_FL_BIT])
        else $error("rising edge did not set external flag");
    // flags fall only through a software write of the register
    ext_flag_hold_a: assert property (
        control[EXT_FL_BIT] && !(accept && hit(avs_address, OFF_CONTROL))
        |=> control[EXT_FL_BIT])
        else $error("external flag dropped without a write");
    pin_flag_hold_a: assert property (
        control[PC_FL_BIT] && !(accept && hit(avs_address, OFF_CONTROL))
        |=> control[PC_FL_BIT])
        else $error("pin-change flag dropped without a write");
    pin_change_a: assert property (
        pin_changed |=> control[PC_FL_BIT])
        else $error("enabled pin change did not set flag");
    unimpl_zero_a: assert property (
        (pie_one & ~PERIPH_ONE_IMPL) == '0
        && (pie_two & ~PERIPH_TWO_IMPL) == '0)
        else $error("unimplemented enable bit set");
    taken_clear_a: assert property (
        core_irq_taken |=> !control[GLB_EN_BIT]
        && core_irq_vector == IRQ_VECTOR ##1 !core_irq_request)
        else $error("taken interrupt did not clear global enable");
    vector_hold_a: assert property (
        !core_irq_taken |=> $stable(core_irq_vector))
        else $error("vector changed without a taken interrupt");
    flag_free_a: assert property (
        !control[GLB_EN_BIT] && !control[EXT_EN_BIT] && ext_edge
        |=> control[EXT_FL_BIT])
        else $error("flag not set while enables were clear");
    irq_level_a: assert property (
        irq == |(ev_status & ev_mask))
        else $error("irq does not follow unmasked event status");
    bus_answer_a: assert property (
        bus_req && avs_waitrequest |=> !avs_waitrequest ##1
        avs_waitrequest)
        else $error("bus answer not one cycle after request");

    taken_c: cover property (core_irq_request ##[1:4] core_irq_taken);
    periph_c: cover property (control[PER_EN_BIT] && periph_hit
                              ##1 core_irq_request);
    pin_chg_c: cover property (pin_changed ##2 irq);
    ext_c: cover property (ext_edge ##1 control[EXT_FL_BIT]);
endmodule // iefc_irq_ctrl

// file: iefc_core_model.sv
// stand-in for the core: takes a request once per grant, returns on command
`timescale 1ns/100ps
module iefc_core_model (
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       serve,
    input  wire logic       ret_go,
    input  wire logic [3:0] lat,
    input  wire logic       core_irq_request,
    output logic            core_irq_taken,
    output logic            core_irq_return
);
    logic       armed;
    logic [3:0] wait_cnt;
    // one take per grant, so a held request cannot retrigger forever
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            armed           <= 1'b0;
            wait_cnt        <= 4'h0;
            core_irq_taken  <= 1'b0;
            core_irq_return <= 1'b0;
        end else begin
            core_irq_taken  <= 1'b0;
            core_irq_return <= ret_go;
            if (serve) begin
                armed    <= 1'b1;
                wait_cnt <= lat;
            end else if (armed && core_irq_request) begin
                // slow core: counts down before taking
                if (wait_cnt == 4'h0) begin
                    core_irq_taken <= 1'b1;
                    armed          <= 1'b0;
                end else begin
                    wait_cnt <= wait_cnt - 4'h1;
                end
            end
        end
    end
endmodule // iefc_core_model

// file: tb_top.sv
// self-checking bench for the interrupt enable and flag block
`timescale 1ns/100ps
module tb_top
    import iefc_pkg::*;
();
    typedef struct { logic [31:0] v; string nm; } iefc_exp_t;
    logic              core_clk = 1'b0;
    logic              reset_n = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic              avs_read = 1'b0;
    logic              avs_write = 1'b0;
    logic [DATA_W-1:0] avs_writedata = '0;
    logic [DATA_W-1:0] avs_readdata;
    logic              avs_waitrequest;
    logic              timer0_rollover = 1'b0;
    logic              ext_pin = 1'b0;
    logic [7:0]        pin_change_in = '0;
    logic [REG_W-1:0]  pir_one_event = '0;
    logic [REG_W-1:0]  pir_two_event = '0;
    logic              core_irq_taken;
    logic              core_irq_return;
    logic              core_irq_request;
    logic [15:0]       core_irq_vector;
    logic              irq;
    logic              serve = 1'b0;
    logic              ret_go = 1'b0;
    logic [3:0]        lat = '0;
    logic [1:0]        probe = '0;
    int                failures = 0;
    int                n_checks = 0;
    iefc_exp_t         q[$];
    iefc_exp_t         e_cur;
    logic [31:0]       seen;

    always #2.5 core_clk = ~core_clk;

    iefc_irq_ctrl #(.PC_W(8)) i_iefc_irq_ctrl (
        .core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .timer0_rollover(timer0_rollover),
        .ext_pin(ext_pin), .pin_change_in(pin_change_in),
        .pir_one_event(pir_one_event), .pir_two_event(pir_two_event),
        .core_irq_taken(core_irq_taken), .core_irq_return(core_irq_return),
        .core_irq_request(core_irq_request),
        .core_irq_vector(core_irq_vector), .irq(irq));

    iefc_core_model i_iefc_core_model (
        .core_clk(core_clk), .reset_n(reset_n), .serve(serve),
        .ret_go(ret_go), .lat(lat), .core_irq_request(core_irq_request),
        .core_irq_taken(core_irq_taken), .core_irq_return(core_irq_return));

    function automatic logic [31:0] bv(input int b);
        return 32'h0000_0001 << b;
    endfunction

    task automatic end_sim;
        if (failures == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] x);
        q.push_back('{x, "avs_readdata"});
        bus(1'b0, a, '0);
    endtask

    // probe 1 irq, 2 core request, 3 vector
    task automatic chk(input logic [1:0] k, input logic [31:0] x);
        q.push_back('{x, k == 2'd1 ? "irq" : "core_irq"});
        probe <= k;
        @(posedge core_clk);
        probe <= 2'd0;
        @(posedge core_clk);
    endtask

    task automatic pulse(input logic t, input logic [15:0] p);
        timer0_rollover <= t;
        pir_one_event   <= p[7:0];
        pir_two_event   <= p[15:8];
        @(posedge core_clk);
        timer0_rollover <= 1'b0;
        pir_one_event   <= 8'h00;
        pir_two_event   <= 8'h00;
        @(posedge core_clk);
    endtask

    always @(posedge core_clk) begin
        if ((avs_read && avs_waitrequest === 1'b0) || probe != 2'd0) begin
            e_cur = q.pop_front();
            seen = probe == 2'd1 ? 32'(irq) : probe == 2'd2 ?
                   32'(core_irq_request) : probe == 2'd3 ?
                   32'(core_irq_vector) : avs_readdata;
            n_checks++;
            if (seen !== e_cur.v) begin
                failures++;
                $display("unexpected %s expected %h seen %h",
                         e_cur.nm, e_cur.v, seen);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        $display("unexpected watchdog expected done seen timeout");
        end_sim();
    end

    initial begin
        int unsigned       r;
        logic [ADDR_W-1:0] pe;
        logic [ADDR_W-1:0] pf;
        logic [REG_W-1:0]  im;
        void'($urandom(55388));
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        rd(OFF_CONTROL, 32'(CONTROL_RST));
        rd(OFF_PIE_ONE, 32'(PIE_RST));
        rd(OFF_PIE_TWO, 32'(PIE_RST));
        rd(OFF_CORE, 32'(VECTOR_RST));
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0000_0000);
        r = $urandom;
        wr(OFF_PIE_ONE, r);
        rd(OFF_PIE_ONE, 32'(r[7:0] & PERIPH_ONE_IMPL));
        wr(OFF_PIE_TWO, 32'hFFFF_FFFF);
        rd(OFF_PIE_TWO, 32'(PERIPH_TWO_IMPL));
        wr(OFF_CONTROL, 32'h0000_0000);
        pulse(1'b1, 16'h0000);
        rd(OFF_CONTROL, bv(T0_FL_BIT));
        rd(OFF_CONTROL, bv(T0_FL_BIT));
        chk(2'd2, 32'h0000_0000);
        // count lives outside, flag cleared directly
        wr(OFF_CONTROL, 32'h0000_0000);
        rd(OFF_CONTROL, 32'h0000_0000);
        for (int i = 0; i < 3; i++) begin
            wr(OFF_CONTROL, bv(GLB_EN_BIT) | bv(T0_EN_BIT - i)
                            | bv(T0_FL_BIT - i));
            chk(2'd2, 32'h0000_0001);
            wr(OFF_CONTROL, bv(T0_EN_BIT - i) | bv(T0_FL_BIT - i));
            chk(2'd2, 32'h0000_0000);
            wr(OFF_CONTROL, bv(GLB_EN_BIT) | bv(T0_FL_BIT - i));
            chk(2'd2, 32'h0000_0000);
        end
        wr(OFF_CONTROL, 32'h0000_0000);
        for (int k = 0; k < 16; k++) begin
            im = k < 8 ? PERIPH_ONE_IMPL : PERIPH_TWO_IMPL;
            pe = k < 8 ? OFF_PIE_ONE : OFF_PIE_TWO;
            pf = k < 8 ? OFF_PIR_ONE : OFF_PIR_TWO;
            if (im[k % 8]) begin
                wr(pe, 32'h0000_0000);
                pulse(1'b0, 16'(bv(k)));
                rd(pf, bv(k % 8));
                wr(OFF_CONTROL, bv(GLB_EN_BIT) | bv(PER_EN_BIT));
                wr(pe, 32'(im) & ~bv(k % 8));
                chk(2'd2, 32'h0000_0000);
                wr(pe, bv(k % 8));
                chk(2'd2, 32'h0000_0001);
                wr(OFF_CONTROL, bv(GLB_EN_BIT));
                chk(2'd2, 32'h0000_0000);
                wr(pf, 32'h0000_0000);
                wr(OFF_CONTROL, 32'h0000_0000);
            end
        end
        wr(OFF_PC_MASK, 32'h0000_0000);
        pin_change_in <= pin_change_in ^ (8'($urandom) | 8'h01);
        repeat (2) @(posedge core_clk);
        rd(OFF_CONTROL, 32'h0000_0000);
        wr(OFF_PC_MASK, 32'h0000_0008);
        pin_change_in <= pin_change_in ^ 8'h08;
        repeat (2) @(posedge core_clk);
        rd(OFF_CONTROL, bv(PC_FL_BIT));
        for (int es = 0; es < 2; es++) begin
            wr(OFF_OPTION, es == 1 ? bv(EDGE_SEL_BIT) : 32'h0000_0000);
            ext_pin <= es[0];
            repeat (2) @(posedge core_clk);
            wr(OFF_CONTROL, 32'h0000_0000);
            ext_pin <= !es[0];
            repeat (2) @(posedge core_clk);
            rd(OFF_CONTROL, 32'h0000_0000);
            ext_pin <= es[0];
            repeat (2) @(posedge core_clk);
            rd(OFF_CONTROL, bv(EXT_FL_BIT));
        end
        wr(OFF_EV_STAT, 32'h0000_001F);
        wr(OFF_EV_MASK, 32'h0000_0000);
        pulse(1'b1, 16'h0000);
        rd(OFF_EV_STAT, bv(EV_TIMER0));
        chk(2'd1, 32'h0000_0000);
        wr(OFF_EV_MASK, bv(EV_TIMER0));
        chk(2'd1, 32'h0000_0001);
        wr(OFF_EV_STAT, bv(EV_TIMER0));
        chk(2'd1, 32'h0000_0000);
        wr(OFF_EV_MASK, bv(EV_TAKEN));
        for (int j = 0; j < 2; j++) begin
            lat <= j == 0 ? 4'h0 : 4'(1 + $urandom % 7);
            wr(OFF_CONTROL, bv(GLB_EN_BIT) | bv(T0_EN_BIT) | bv(T0_FL_BIT));
            serve <= 1'b1;
            @(posedge core_clk);
            serve <= 1'b0;
            // a core that never takes is caught by the watchdog
            while (core_irq_taken !== 1'b1) begin
                @(posedge core_clk);
            end
            rd(OFF_CONTROL, bv(T0_EN_BIT) | bv(T0_FL_BIT));
            chk(2'd3, 32'h0000_0004);
            chk(2'd2, 32'h0000_0000);
            chk(2'd1, 32'h0000_0001);
            wr(OFF_EV_STAT, bv(EV_TAKEN));
            wr(OFF_CONTROL, bv(T0_EN_BIT));
            ret_go <= 1'b1;
            @(posedge core_clk);
            ret_go <= 1'b0;
            repeat (3) @(posedge core_clk);
            rd(OFF_CONTROL, bv(GLB_EN_BIT) | bv(T0_EN_BIT));
        end
        repeat (4) @(posedge core_clk);
        end_sim();
    end
endmodule // tb_top
